//--- shared/asr_pkg.sv
/*
 * Constants, register map and carrier types of the analog speed reference.
 * Assumes a 50 MHz system clock and frequencies in units of 0.01 Hz.
 */
package asr_pkg;

	// ==========================================================
	// Widths and timing
	localparam int unsigned ADC_W         = 12;
	localparam int unsigned FREQ_W        = 16;
	localparam int unsigned PCT_W         = 7;
	localparam int unsigned VOUT_W        = 12;
	localparam int unsigned HIST_DEPTH    = 32;
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned SAMPLE_MS     = 2;
	localparam int unsigned SAMPLE_CYC    = CLK_HZ / 1000 * SAMPLE_MS;
	localparam int unsigned DB_INIT_MS    = 500;
	localparam int unsigned DB_INIT_CYC   = CLK_HZ / 1000 * DB_INIT_MS;
	localparam int unsigned DB_SAMPLES    = 16;
	localparam int unsigned FILT_MAX_AVG  = 30;

	// ==========================================================
	// Value limits and reset values
	localparam logic [11:0] ADC_FULL      = 12'hFFF;
	localparam logic [11:0] VOUT_FULL     = 12'hFFF;
	localparam logic [15:0] FREQ_LIMIT    = 16'h9C40;
	localparam logic [15:0] BASE_MIN      = 16'h0BB8;
	localparam logic [15:0] FREQ_DFLT     = 16'h1770;
	localparam logic [15:0] DB_BAND       = 16'h000A;
	localparam logic [6:0]  PCT_LIMIT     = 7'h64;
	localparam logic [6:0]  START_PCT_RST = 7'h00;
	localparam logic [6:0]  END_PCT_RST   = 7'h64;
	localparam logic [15:0] MAP_FREQ_RST  = 16'h0000;
	localparam logic [4:0]  FILT_RST      = 5'h08;
	localparam logic [4:0]  FILT_DBAND    = 5'h1F;

	// ==========================================================
	// Setting codes
	localparam logic [1:0] EN_OFFSET      = 2'h0;
	localparam logic [1:0] EN_ZERO        = 2'h1;
	localparam logic [1:0] SRC_VOLT_CUR   = 2'h0;
	localparam logic [1:0] SRC_VOLT_POT   = 2'h2;
	localparam logic [1:0] SRC_CUR_POT    = 2'h3;
	localparam logic [1:0] SRC_RST        = 2'h0;
	localparam logic [3:0] FSRC_TERMINAL  = 4'h1;
	localparam logic [3:0] FSRC_RST       = 4'h2;

	// ==========================================================
	// Register offsets and field positions
	localparam logic [7:0] OFF_SRC        = 8'h00;
	localparam logic [7:0] OFF_FILT       = 8'h04;
	localparam logic [7:0] OFF_VSF        = 8'h08;
	localparam logic [7:0] OFF_VEF        = 8'h0C;
	localparam logic [7:0] OFF_VPCT       = 8'h10;
	localparam logic [7:0] OFF_ENA        = 8'h14;
	localparam logic [7:0] OFF_CSF        = 8'h18;
	localparam logic [7:0] OFF_CEF        = 8'h1C;
	localparam logic [7:0] OFF_CPCT       = 8'h20;
	localparam logic [7:0] OFF_BASE1      = 8'h24;
	localparam logic [7:0] OFF_MAX1       = 8'h28;
	localparam logic [7:0] OFF_BASE2      = 8'h2C;
	localparam logic [7:0] OFF_MAX2       = 8'h30;
	localparam logic [7:0] OFF_FREQ       = 8'h34;
	localparam logic [7:0] OFF_VCMD       = 8'h38;
	localparam int unsigned AT_ASSIGN_BIT = 2;
	localparam int unsigned MOTOR_BIT     = 3;
	localparam int unsigned FSRC_LSB      = 4;
	localparam int unsigned END_PCT_LSB   = 8;
	localparam int unsigned CUR_EN_LSB    = 2;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic [15:0] start_freq;
		logic [15:0] end_freq;
		logic [6:0]  start_pct;
		logic [6:0]  end_pct;
		logic [1:0]  start_en;
	} asr_map_cfg_t;

	typedef enum logic [1:0] {
		DB_SETTLE = 2'b01,
		DB_HOLD   = 2'b10
	} asr_db_state_t;

endpackage

//--- src/asr_lin_map.sv
/*
 * Linear map of one analog level onto a frequency segment.
 * Assumes the level comes from logic on the same clock.
 */
module asr_lin_map import asr_pkg::*; (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [11:0]  level,
	input  wire asr_map_cfg_t cfg,
	output logic [15:0]       freq_r
);

	// ==========================================================
	// Segment arithmetic
	logic        [18:0] x100;
	logic        [18:0] lo;
	logic        [18:0] hi;
	logic        [18:0] off;
	logic        [18:0] span;
	logic signed [16:0] df;
	logic signed [36:0] q;
	logic signed [36:0] res;
	logic        [15:0] freq_nxt;

	// Percent compare without a divider: level*100 vs pct*full
	assign x100 = 19'(level) * 19'd100;
	assign lo   = 19'(cfg.start_pct) * 19'(ADC_FULL);
	assign hi   = 19'(cfg.end_pct) * 19'(ADC_FULL);
	assign off  = x100 - lo;
	assign span = hi - lo;
	assign df   = $signed({1'b0, cfg.end_freq}) -
	              $signed({1'b0, cfg.start_freq});

	always_comb begin
		q   = '0;
		res = '0;
		if (x100 < lo) begin
			freq_nxt = (cfg.start_en == EN_OFFSET) ?
			           cfg.start_freq : 16'h0000;
		end else if (x100 >= hi) begin
			freq_nxt = cfg.end_freq;
		end else begin
			q   = (37'(df) * 37'($signed({1'b0, off}))) /
			      37'($signed({1'b0, span}));
			res = 37'($signed({1'b0, cfg.start_freq})) + q;
			freq_nxt = res[15:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_r <= 16'h0000;
		end else begin
			freq_r <= freq_nxt;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_map_above;
		(x100 >= hi) && (x100 >= lo) |=> freq_r == $past(cfg.end_freq);
	endproperty
	a_map_above: assert property (p_map_above)
		else $error("level above window not mapped to end frequency");

	property p_map_below;
		(x100 < lo) && (cfg.start_en == EN_ZERO) |=> freq_r == 16'h0000;
	endproperty
	a_map_below: assert property (p_map_below)
		else $error("level below window not forced to zero");

endmodule

//--- src/asr_speed_ref.sv
/*
 * Analog speed reference: source select, linear maps, averaging and
 * deadband filter, motor frequency limits and V/f command.
 * Assumes analog samples arrive on clk; the select terminal is a pin.
 */
// Summary of operation
// - Voltage level mapped linearly onto frequency segment
// - Below voltage window output zero or start
// - Start enable code 00 offset, 01 zero
// - Above voltage window hold end frequency
// - Current input uses its own segment
// - Below current window zero or start frequency
// - Above current window hold end frequency
// - Map frequencies accepted from 0 to 400 Hz
// - Window points 0 to 100 percent, defaults
// - Select code chooses pair, terminal picks one
// - Without terminal assignment, sum voltage and current
// - Settings 1 to 30 average n samples
// - Setting 31 averages, deadband after 500 ms settle
// - Deadband ignores changes under 0.1 Hz
// - Base frequency from 30 Hz to maximum
// - Maximum from base to 400 Hz, default 60
// - Voltage rises with frequency to base, then flat
// - Two motor sets of base and maximum
// - Terminal frequency source uses analog reference
module asr_speed_ref import asr_pkg::*; #(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYC,
	parameter int unsigned INIT_CYCLES   = DB_INIT_CYC,
	parameter int unsigned DB_N          = DB_SAMPLES
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] volt_in,
	input  wire logic [11:0] current_input,
	input  wire logic [11:0] external_potentiometer,
	input  wire logic        analog_select_terminal,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [31:0]      reg_rdata,
	output logic [15:0]      freq_ref,
	output logic [11:0]      volt_cmd
);

	// ==========================================================
	// Parameter checks
	if (DB_N < 1 || DB_N > FILT_MAX_AVG || SAMPLE_CYCLES < 1 ||
	    INIT_CYCLES < 1) begin : g_param_bad
		$error("asr_speed_ref: parameter out of range");
	end

	// ==========================================================
	// Settings
	logic [1:0]   src_r, src_nxt;
	logic         at_asg_r, at_asg_nxt;
	logic         motor_r, motor_nxt;
	logic [3:0]   fsrc_r, fsrc_nxt;
	logic [4:0]   filt_r, filt_nxt;
	asr_map_cfg_t vcfg_r, vcfg_nxt;
	asr_map_cfg_t ccfg_r, ccfg_nxt;
	logic [15:0]  base1_r, base1_nxt, max1_r, max1_nxt;
	logic [15:0]  base2_r, base2_nxt, max2_r, max2_nxt;
	logic         hist_clr;

	function automatic logic [15:0] clampf(input logic [15:0] v,
	                                       input logic [15:0] lo,
	                                       input logic [15:0] hi);
		if (v < lo) begin
			return lo;
		end else if (v > hi) begin
			return hi;
		end
		return v;
	endfunction

	function automatic logic [6:0] clampp(input logic [6:0] v);
		return (v > PCT_LIMIT) ? PCT_LIMIT : v;
	endfunction

	always_comb begin
		src_nxt    = src_r;
		at_asg_nxt = at_asg_r;
		motor_nxt  = motor_r;
		fsrc_nxt   = fsrc_r;
		filt_nxt   = filt_r;
		vcfg_nxt   = vcfg_r;
		ccfg_nxt   = ccfg_r;
		base1_nxt  = base1_r;
		max1_nxt   = max1_r;
		base2_nxt  = base2_r;
		max2_nxt   = max2_r;
		hist_clr   = 1'b0;
		if (reg_wr) begin
			unique case (reg_addr)
			OFF_SRC: begin
				src_nxt    = reg_wdata[1:0];
				at_asg_nxt = reg_wdata[AT_ASSIGN_BIT];
				motor_nxt  = reg_wdata[MOTOR_BIT];
				fsrc_nxt   = reg_wdata[FSRC_LSB +: 4];
			end
			OFF_FILT: begin
				// Zero is not a legal setting; such a write is dropped
				if (reg_wdata[4:0] != 5'h00) begin
					filt_nxt = reg_wdata[4:0];
					hist_clr = 1'b1;
				end
			end
			OFF_VSF: vcfg_nxt.start_freq =
				clampf(reg_wdata[15:0], 16'h0000, FREQ_LIMIT);
			OFF_VEF: vcfg_nxt.end_freq =
				clampf(reg_wdata[15:0], 16'h0000, FREQ_LIMIT);
			OFF_VPCT: begin
				vcfg_nxt.start_pct = clampp(reg_wdata[6:0]);
				vcfg_nxt.end_pct = clampp(reg_wdata[END_PCT_LSB +: 7]);
			end
			OFF_ENA: begin
				vcfg_nxt.start_en = reg_wdata[1:0];
				ccfg_nxt.start_en = reg_wdata[CUR_EN_LSB +: 2];
			end
			OFF_CSF: ccfg_nxt.start_freq =
				clampf(reg_wdata[15:0], 16'h0000, FREQ_LIMIT);
			OFF_CEF: ccfg_nxt.end_freq =
				clampf(reg_wdata[15:0], 16'h0000, FREQ_LIMIT);
			OFF_CPCT: begin
				ccfg_nxt.start_pct = clampp(reg_wdata[6:0]);
				ccfg_nxt.end_pct = clampp(reg_wdata[END_PCT_LSB +: 7]);
			end
			OFF_BASE1: base1_nxt =
				clampf(reg_wdata[15:0], BASE_MIN, max1_r);
			OFF_MAX1: max1_nxt =
				clampf(reg_wdata[15:0], base1_r, FREQ_LIMIT);
			OFF_BASE2: base2_nxt =
				clampf(reg_wdata[15:0], BASE_MIN, max2_r);
			OFF_MAX2: max2_nxt =
				clampf(reg_wdata[15:0], base2_r, FREQ_LIMIT);
			default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			src_r    <= SRC_RST;
			at_asg_r <= 1'b1;
			motor_r  <= 1'b0;
			fsrc_r   <= FSRC_RST;
			filt_r   <= FILT_RST;
			vcfg_r   <= '{MAP_FREQ_RST, MAP_FREQ_RST, START_PCT_RST,
			              END_PCT_RST, EN_ZERO};
			ccfg_r   <= '{MAP_FREQ_RST, MAP_FREQ_RST, START_PCT_RST,
			              END_PCT_RST, EN_ZERO};
			base1_r  <= FREQ_DFLT;
			max1_r   <= FREQ_DFLT;
			base2_r  <= FREQ_DFLT;
			max2_r   <= FREQ_DFLT;
		end else begin
			src_r    <= src_nxt;
			at_asg_r <= at_asg_nxt;
			motor_r  <= motor_nxt;
			fsrc_r   <= fsrc_nxt;
			filt_r   <= filt_nxt;
			vcfg_r   <= vcfg_nxt;
			ccfg_r   <= ccfg_nxt;
			base1_r  <= base1_nxt;
			max1_r   <= max1_nxt;
			base2_r  <= base2_nxt;
			max2_r   <= max2_nxt;
		end
	end

	// ==========================================================
	// Input maps and source selection
	logic [15:0] vmap, cmap, pmap, raw;
	logic [16:0] sum_vc;
	logic [15:0] act_base, act_max;
	logic        at_s1_r, at_s2_r;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			at_s1_r <= 1'b0;
			at_s2_r <= 1'b0;
		end else begin
			at_s1_r <= analog_select_terminal;
			at_s2_r <= at_s1_r;
		end
	end

	asr_lin_map u_vmap (
		.clk    (clk),
		.rst_n  (rst_n),
		.level  (volt_in),
		.cfg    (vcfg_r),
		.freq_r (vmap)
	);

	asr_lin_map u_cmap (
		.clk    (clk),
		.rst_n  (rst_n),
		.level  (current_input),
		.cfg    (ccfg_r),
		.freq_r (cmap)
	);

	assign act_base = motor_r ? base2_r : base1_r;
	assign act_max  = motor_r ? max2_r : max1_r;
	// Potentiometer spans zero to the active maximum
	assign pmap = 16'((28'(external_potentiometer) * 28'(act_max)) /
	                  28'(ADC_FULL));
	assign sum_vc = 17'(vmap) + 17'(cmap);

	always_comb begin
		if (!at_asg_r) begin
			// Sum may pass the limit; saturate before averaging
			raw = (sum_vc > 17'(FREQ_LIMIT)) ? FREQ_LIMIT :
			      sum_vc[15:0];
		end else begin
			unique case (src_r)
			SRC_VOLT_CUR: raw = at_s2_r ? cmap : vmap;
			SRC_VOLT_POT: raw = at_s2_r ? pmap : vmap;
			SRC_CUR_POT:  raw = at_s2_r ? pmap : cmap;
			default:      raw = vmap;
			endcase
		end
	end

	// ==========================================================
	// Sample timing and moving average
	logic [31:0]   tick_cnt_r, tick_cnt_nxt;
	logic          tick;
	logic [15:0]   hist_r [HIST_DEPTH];
	logic [4:0]    wp_r, wp_nxt, n_eff;
	logic [20:0]   sum_r, sum_nxt;
	logic [15:0]   avg, oldest;
	logic          db_mode;

	assign tick    = (tick_cnt_r == 32'(SAMPLE_CYCLES - 1));
	assign db_mode = (filt_r == FILT_DBAND);
	assign n_eff   = db_mode ? 5'(DB_N) : filt_r;
	assign oldest  = hist_r[wp_r - n_eff];
	assign avg     = 16'(sum_r / 21'(n_eff));

	always_comb begin
		tick_cnt_nxt = tick ? 32'h0000_0000 : tick_cnt_r + 32'h1;
		wp_nxt       = wp_r;
		sum_nxt      = sum_r;
		if (hist_clr) begin
			wp_nxt  = 5'h00;
			sum_nxt = '0;
		end else if (tick) begin
			// Running sum: add newest, drop the one n samples back
			wp_nxt  = wp_r + 5'h01;
			sum_nxt = sum_r + 21'(raw) - 21'(oldest);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_r <= 32'h0000_0000;
			wp_r       <= 5'h00;
			sum_r      <= '0;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_r[i] <= 16'h0000;
			end
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
			wp_r       <= wp_nxt;
			sum_r      <= sum_nxt;
			// Clearing keeps the running sum consistent after n changes
			for (int i = 0; i < HIST_DEPTH; i++) begin
				if (hist_clr) begin
					hist_r[i] <= 16'h0000;
				end else if (tick && wp_r == 5'(i)) begin
					hist_r[i] <= raw;
				end
			end
		end
	end

	// ==========================================================
	// Deadband filter
	asr_db_state_t db_st_r, db_st_nxt;
	logic [31:0]   init_cnt_r, init_cnt_nxt;
	logic [15:0]   dref_r, dref_nxt, dlt;

	assign dlt = (avg >= dref_r) ? avg - dref_r : dref_r - avg;

	always_comb begin
		db_st_nxt    = db_st_r;
		init_cnt_nxt = init_cnt_r;
		dref_nxt     = dref_r;
		if (!db_mode || hist_clr) begin
			db_st_nxt    = DB_SETTLE;
			init_cnt_nxt = 32'h0000_0000;
		end else begin
			unique case (db_st_r)
			DB_SETTLE: begin
				dref_nxt = avg;
				if (init_cnt_r == 32'(INIT_CYCLES - 1)) begin
					db_st_nxt = DB_HOLD;
				end else begin
					init_cnt_nxt = init_cnt_r + 32'h1;
				end
			end
			DB_HOLD: begin
				// Small wander is ignored for a steady speed
				if (tick && dlt >= DB_BAND) begin
					dref_nxt = avg;
				end
			end
			default: db_st_nxt = DB_SETTLE;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			db_st_r    <= DB_SETTLE;
			init_cnt_r <= 32'h0000_0000;
			dref_r     <= 16'h0000;
		end else begin
			db_st_r    <= db_st_nxt;
			init_cnt_r <= init_cnt_nxt;
			dref_r     <= dref_nxt;
		end
	end

	// ==========================================================
	// Limits, frequency source and V/f
	logic [15:0] filt_out, lim, freq_nxt;
	logic [11:0] vcmd_nxt;
	logic [31:0] rdata_nxt;

	assign filt_out = db_mode ? dref_r : avg;
	assign lim      = clampf(filt_out, 16'h0000, act_max);
	assign freq_nxt = (fsrc_r == FSRC_TERMINAL) ? lim : 16'h0000;
	assign vcmd_nxt = (freq_ref >= act_base) ? VOUT_FULL :
	                  12'((28'(freq_ref) * 28'(VOUT_FULL)) /
	                      28'(act_base));

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (reg_rd) begin
			unique case (reg_addr)
			OFF_SRC:   rdata_nxt = 32'({fsrc_r, motor_r, at_asg_r, src_r});
			OFF_FILT:  rdata_nxt = 32'(filt_r);
			OFF_VSF:   rdata_nxt = 32'(vcfg_r.start_freq);
			OFF_VEF:   rdata_nxt = 32'(vcfg_r.end_freq);
			OFF_VPCT:  rdata_nxt = 32'({1'b0, vcfg_r.end_pct,
			                            1'b0, vcfg_r.start_pct});
			OFF_ENA:   rdata_nxt = 32'({ccfg_r.start_en, vcfg_r.start_en});
			OFF_CSF:   rdata_nxt = 32'(ccfg_r.start_freq);
			OFF_CEF:   rdata_nxt = 32'(ccfg_r.end_freq);
			OFF_CPCT:  rdata_nxt = 32'({1'b0, ccfg_r.end_pct,
			                            1'b0, ccfg_r.start_pct});
			OFF_BASE1: rdata_nxt = 32'(base1_r);
			OFF_MAX1:  rdata_nxt = 32'(max1_r);
			OFF_BASE2: rdata_nxt = 32'(base2_r);
			OFF_MAX2:  rdata_nxt = 32'(max2_r);
			OFF_FREQ:  rdata_nxt = 32'(freq_ref);
			OFF_VCMD:  rdata_nxt = 32'(volt_cmd);
			default:   rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			freq_ref  <= 16'h0000;
			volt_cmd  <= 12'h000;
			reg_rdata <= 32'h0000_0000;
		end else begin
			freq_ref  <= freq_nxt;
			volt_cmd  <= vcmd_nxt;
			reg_rdata <= rdata_nxt;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_limit;
		freq_ref <= $past(act_max) || $changed(act_max);
	endproperty
	a_limit: assert property (p_limit)
		else $error("reference above active maximum");

	property p_fsrc;
		fsrc_r != FSRC_TERMINAL |=> freq_ref == 16'h0000;
	endproperty
	a_fsrc: assert property (p_fsrc)
		else $error("reference driven while source not terminal");

	property p_base;
		base1_r >= BASE_MIN && base1_r <= max1_r && base2_r >= BASE_MIN;
	endproperty
	a_base: assert property (p_base)
		else $error("base frequency outside its range");

	property p_max;
		max1_r <= FREQ_LIMIT && max2_r <= FREQ_LIMIT && max2_r >= base2_r;
	endproperty
	a_max: assert property (p_max)
		else $error("maximum frequency outside its range");

	property p_vf_flat;
		freq_ref >= act_base ##1 $stable(act_base) |-> volt_cmd == VOUT_FULL;
	endproperty
	a_vf_flat: assert property (p_vf_flat)
		else $error("voltage not full scale above base frequency");

	property p_dband_hold;
		db_mode && db_st_r == DB_HOLD && tick && dlt < DB_BAND &&
		!reg_wr |=> $stable(dref_r);
	endproperty
	a_dband_hold: assert property (p_dband_hold)
		else $error("deadband reference moved inside the band");

	property p_filt_legal;
		filt_r != 5'h00;
	endproperty
	a_filt_legal: assert property (p_filt_legal)
		else $error("filter setting zero");

	property p_sum_sel;
		!at_asg_r && sum_vc <= 17'(FREQ_LIMIT) |-> raw == sum_vc[15:0];
	endproperty
	a_sum_sel: assert property (p_sum_sel)
		else $error("unassigned terminal does not sum inputs");

endmodule

//--- testbench/asr_afe_model.sv
/*
 * Analog front end model: voltage, current and pot levels.
 * Assumes the bench sets target levels; output is registered on clk.
 */
module asr_afe_model (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [11:0] v_set,
	input  wire logic [11:0] c_set,
	input  wire logic [11:0] p_set,
	output logic [11:0]      volt_lvl,
	output logic [11:0]      cur_lvl,
	output logic [11:0]      pot_lvl
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Converter holds last sample, zero in reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			volt_lvl <= 12'h000;
			cur_lvl  <= 12'h000;
			pot_lvl  <= 12'h000;
		end else begin
			volt_lvl <= v_set;
			cur_lvl  <= c_set;
			pot_lvl  <= p_set;
		end
	end
endmodule

//--- testbench/testbench.sv
/*
 * Self-checking bench of the analog speed reference.
 * Assumes shortened sample and settle counts; front end model at inputs.
 */
module testbench import asr_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, term, wr, rd;
	logic [11:0] v_set, c_set, p_set, vl, cl, pl, lv;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata;
	logic [15:0] freq_ref, f0;
	logic [11:0] volt_cmd;
	int          n_errors, comparisons, cyc, e;
	asr_speed_ref #(.SAMPLE_CYCLES(4), .INIT_CYCLES(50), .DB_N(16)) u_dut (
		.clk(clk), .rst_n(rst_n), .volt_in(vl), .current_input(cl),
		.external_potentiometer(pl), .analog_select_terminal(term),
		.reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
		.reg_rdata(rdata), .freq_ref(freq_ref), .volt_cmd(volt_cmd));
	asr_afe_model u_afe (.clk(clk), .rst_n(rst_n), .v_set(v_set),
		.c_set(c_set), .p_set(p_set), .volt_lvl(vl), .cur_lvl(cl),
		.pot_lvl(pl));
	// ==========================================================
	// Clock, timeout and verdict
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Bus cycles and comparisons
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1; addr <= a; wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic chk_eq(string nm, logic [31:0] ex, logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			n_errors++;
			$display("unexpected %s exp %h got %h", nm, ex, got);
		end
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] ex);
		@(posedge clk);
		rd <= 1'b1; addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk_eq("reg_rdata", ex, rdata);
	endtask
	task automatic chk_near(string nm, int ex, logic [15:0] got, int tol);
		comparisons++;
		if ($isunknown(got) || int'(got) > ex + tol || int'(got) < ex - tol)
		begin
			n_errors++;
			$display("unexpected %s exp %0d got %0d", nm, ex, got);
		end
	endtask
	task automatic drive(logic [11:0] v, c, p, logic t, int n);
		@(posedge clk);
		v_set <= v; c_set <= c; p_set <= p; term <= t;
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Straight line with window limits, in 0.01 Hz
	function automatic int fmap(int l, sf, ef, sp, ep, en);
		real p;
		p = l * 100.0 / 4095.0;
		if (p < sp) return (en == 0) ? sf : 0;
		if (p > ep) return ef;
		return sf + int'((ef - sf) * (p - sp) / (ep - sp));
	endfunction
	function automatic int mn(int a, b);
		return (a < b) ? a : b;
	endfunction
	// ==========================================================
	// Main sequence
	initial begin
		{rst_n, term, wr, rd, addr, wdata, v_set, c_set, p_set} = '0;
		void'($urandom(32'hA9284724));
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_rd(OFF_FILT, 32'h8);
		chk_rd(OFF_SRC, 32'h24);
		chk_rd(OFF_VPCT, 32'h6400);
		chk_rd(OFF_ENA, 32'h5);
		chk_rd(OFF_BASE1, 32'h1770);
		chk_rd(OFF_MAX2, 32'h1770);
		chk_rd(8'hFC, 32'h0);
		chk_eq("freq_ref", 32'h0, freq_ref);
		wr_reg(OFF_MAX1, 32'h9C40);
		wr_reg(OFF_FILT, 32'h1);
		wr_reg(OFF_VSF, 32'd1000);
		wr_reg(OFF_VEF, 32'd30000);
		wr_reg(OFF_VPCT, 32'h5014);
		wr_reg(OFF_CSF, 32'd2000);
		wr_reg(OFF_CEF, 32'd12000);
		wr_reg(OFF_CPCT, 32'h5A0A);
		wr_reg(OFF_SRC, 32'h14);
		for (int en = 0; en < 2; en++) begin
			wr_reg(OFF_ENA, en * 5);
			for (int k = 0; k < 6; k++) begin
				lv = (k == 0) ? 12'h000 : (k == 1) ? 12'hFFF : 12'($urandom);
				drive(lv, ~lv, 12'h000, 1'b0, 24);
				e = fmap(lv, 1000, 30000, 20, 80, en);
				chk_near("freq_ref", e, freq_ref, 600);
				drive(lv, ~lv, 12'h000, 1'b1, 24);
				e = fmap(4095 - lv, 2000, 12000, 10, 90, en);
				chk_near("freq_ref", e, freq_ref, 200);
			end
		end
		wr_reg(OFF_SRC, 32'h10);
		lv = 12'($urandom);
		drive(lv, ~lv, 12'h000, 1'b1, 24);
		e = fmap(lv, 1000, 30000, 20, 80, 1) +
		    fmap(4095 - lv, 2000, 12000, 10, 90, 1);
		chk_near("freq_ref", mn(e, 40000), freq_ref, 800);
		for (int code = 2; code < 4; code++) begin
			wr_reg(OFF_SRC, 32'h14 | code);
			lv = 12'($urandom);
			drive(12'h000, 12'h000, lv, 1'b1, 24);
			chk_near("freq_ref", lv * 40000 / 4095, freq_ref, 800);
			drive(12'hFFF, 12'hFFF, lv, 1'b0, 24);
			e = (code == 2) ? 30000 : 12000;
			chk_near("freq_ref", e, freq_ref, 40);
		end
		wr_reg(OFF_SRC, 32'h1C);
		wr_reg(OFF_MAX2, 32'h9C40);
		wr_reg(OFF_MAX1, 32'd5000);
		chk_rd(OFF_MAX1, 32'h1770);
		wr_reg(OFF_BASE1, 32'd1000);
		chk_rd(OFF_BASE1, 32'h0BB8);
		wr_reg(OFF_VEF, 32'd50000);
		chk_rd(OFF_VEF, 32'h9C40);
		wr_reg(OFF_VPCT, 32'h7878);
		chk_rd(OFF_VPCT, 32'h6464);
		wr_reg(OFF_VPCT, 32'h6400);
		wr_reg(OFF_VSF, 32'd0);
		wr_reg(OFF_VEF, 32'd20000);
		drive(12'hFFF, 12'h000, 12'h000, 1'b0, 24);
		chk_near("freq_ref", 20000, freq_ref, 40);
		wr_reg(OFF_SRC, 32'h14);
		drive(12'hFFF, 12'h000, 12'h000, 1'b0, 24);
		chk_near("freq_ref", 6000, freq_ref, 0);
		chk_eq("volt_cmd", 32'hFFF, volt_cmd);
		drive(12'd400, 12'h000, 12'h000, 1'b0, 24);
		e = fmap(400, 0, 20000, 0, 100, 1);
		chk_near("volt_cmd", e * 4095 / 3000, volt_cmd, 60);
		wr_reg(OFF_SRC, 32'h1C);
		drive(12'd3000, 12'h000, 12'h000, 1'b0, 24);
		wr_reg(OFF_FILT, 32'h8);
		repeat (6) @(posedge clk);
		#1;
		e = fmap(3000, 0, 20000, 0, 100, 1);
		chk_near("freq_ref", e / 4, freq_ref, e / 4);
		drive(12'd3000, 12'h000, 12'h000, 1'b0, 60);
		chk_near("freq_ref", e, freq_ref, 40);
		wr_reg(OFF_FILT, 32'h1F);
		drive(12'd2000, 12'h000, 12'h000, 1'b0, 200);
		e = fmap(2000, 0, 20000, 0, 100, 1);
		chk_near("freq_ref", e, freq_ref, 40);
		f0 = freq_ref;
		drive(12'd2001, 12'h000, 12'h000, 1'b0, 200);
		chk_eq("freq_ref", f0, freq_ref);
		drive(12'd2600, 12'h000, 12'h000, 1'b0, 200);
		e = fmap(2600, 0, 20000, 0, 100, 1);
		chk_near("freq_ref", e, freq_ref, 40);
		chk_rd(OFF_FREQ, 32'(e));
		chk_rd(OFF_VCMD, 32'hFFF);
		print_verdict();
	end
endmodule
